// *** logic/ebu_break_unit.sv ***
// break event unit: soft and hard breakpoints, event combination, break sources and break timer
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: one break mode, soft or hard, host selects it, device reports it.
// R2: soft mode halts before the instruction at a matching address executes.
// R3: eight soft breakpoint addresses, each set or cleared independently.
// R4: hard mode halts only after the instruction at a matching address completes.
// R5: two hard comparators, each set or cleared independently.
// R6: a hard condition may be an address range or external trigger.
// R7: combined event built from two address events and one trigger event.
// R8: AND mode fires only when every enabled component is true.
// R9: OR mode fires when any enabled component is true.
// R10: sequential mode fires after components occur in programmed first, second, third order.
// R11: several break sources may be enabled; any enabled source halts.
// R12: breakpoint source enabled halts on the combined breakpoint event.
// R13: stack source enabled halts on stack overflow or underflow.
// R14: trace event source enabled halts when the trace event is met.
// R15: trace full source enabled halts when trace memory is full.
// R16: timer off mode never adds a break condition.
// R17: timeout mode halts if breakpoint recurs within interval, armed after first hit.
// R18: elapsed mode halts when interval has passed since execution began.
// R19: delay mode halts when interval has passed after the breakpoint hit.
// R20: time base source counts ticks of a fixed ten microsecond base.
// R21: cycle source advances once per target machine cycle.
// R22: timer count accepted only within two to 65535.
// R23: external trigger is synchronised before use, one clean event per change.
module ebu_break_unit #(
	parameter int ADDR_W = ebu_pkg::ADDR_W,
	parameter int NSOFT  = ebu_pkg::SOFT_BP_NUM
) (
	input  wire logic                              REF_CLK,
	input  wire logic                              RST_N,
	input  wire logic                              HARD_BREAK_SEL,
	input  wire logic [NSOFT-1:0][ADDR_W-1:0]      SOFT_BP_ADDR,
	input  wire logic [NSOFT-1:0]                  SOFT_BP_EN,
	input  wire ebu_pkg::ebu_hw_bp_t               HARD_BP_ONE,
	input  wire ebu_pkg::ebu_hw_bp_t               HARD_BP_TWO,
	input  wire logic                              TRIG_EN,
	input  wire logic                              TRIG_ACTIVE_HIGH,
	input  wire logic                              TRIG_IN,
	input  wire ebu_pkg::ebu_comb_t                COMB_MODE,
	input  wire ebu_pkg::ebu_step_t                SEQ_FIRST,
	input  wire ebu_pkg::ebu_step_t                SEQ_SECOND,
	input  wire ebu_pkg::ebu_step_t                SEQ_THIRD,
	input  wire ebu_pkg::ebu_src_en_t              SRC_EN,
	input  wire ebu_pkg::ebu_tmode_t               TIMER_MODE,
	input  wire logic                              TIMER_CYCLE_SRC,
	input  wire logic [ebu_pkg::TIMER_W-1:0]       TIMER_COUNT,
	input  wire logic                              TIMER_COUNT_WR,
	input  wire logic                              RUN_START,
	input  wire logic                              TARGET_RUN,
	input  wire logic                              FETCH_VALID,
	input  wire logic [ADDR_W-1:0]                 FETCH_ADDR,
	input  wire logic                              EXEC_DONE,
	input  wire logic [ADDR_W-1:0]                 EXEC_ADDR,
	input  wire logic                              MACHINE_CYCLE,
	input  wire logic                              STACK_OVERFLOW,
	input  wire logic                              STACK_UNDERFLOW,
	input  wire logic                              TRACE_EVENT,
	input  wire logic                              TRACE_FULL,
	output logic                                   HARD_MODE_ACTIVE,
	output logic                                   HALT_BEFORE,
	output logic                                   HALT_AFTER,
	output logic                                   HALT_REQ,
	output logic [ebu_pkg::CAUSE_W-1:0]            BREAK_CAUSE,
	output logic                                   COUNT_REJECT,
	output logic [ebu_pkg::TIMER_W-1:0]            TIMER_LIMIT
);

	// all state of the unit
	typedef struct packed {
		logic                          hard_mode;
		logic [2:0]                    trig_sync;
		logic [1:0]                    stage;
		logic                          armed;
		logic [ebu_pkg::TIMER_W-1:0]   tcount;
		logic [ebu_pkg::DIV_W-1:0]     div;
		logic [ebu_pkg::TIMER_W-1:0]   limit;
		logic                          reject;
		logic                          halt_before;
		logic                          halt_after;
		logic                          halt_req;
		logic [ebu_pkg::CAUSE_W-1:0]   cause;
	} ebu_state_t;

	ebu_state_t s;
	ebu_state_t next_s;

	logic              soft_hit;
	logic              ev_one;
	logic              ev_two;
	logic              ev_trig;
	logic [3:0]        ev_by_step;
	logic [2:0]        comp_en;
	logic [2:0]        comp_ev;
	logic              comb_and;
	logic              comb_or;
	logic              seq_fire;
	logic [1:0]        next_stage;
	ebu_pkg::ebu_step_t cur_step;
	ebu_pkg::ebu_step_t after_step;
	logic              bp_hit;
	logic              bp_direct;
	logic              tick;
	logic              div_wrap;
	logic              expired;
	logic              timer_halt;
	logic              src_halt;
	logic [ebu_pkg::CAUSE_W-1:0] cause_set;

	// soft breakpoint compare against the address about to execute
	always_comb begin
		soft_hit = 1'b0;
		for (int i = 0; i < NSOFT; i++) begin
			if (SOFT_BP_EN[i] && FETCH_ADDR == SOFT_BP_ADDR[i]) begin // [R3]
				soft_hit = FETCH_VALID & ~s.hard_mode; // [R2]
			end
		end
	end

	// hard comparators on the completed instruction, single address or range
	always_comb begin
		ev_one = EXEC_DONE && HARD_BP_ONE.enable && (HARD_BP_ONE.range ? // [R5]
			(EXEC_ADDR >= HARD_BP_ONE.lo && EXEC_ADDR <= HARD_BP_ONE.hi) : // [R6]
			(EXEC_ADDR == HARD_BP_ONE.lo));
		ev_two = EXEC_DONE && HARD_BP_TWO.enable && (HARD_BP_TWO.range ? // [R5]
			(EXEC_ADDR >= HARD_BP_TWO.lo && EXEC_ADDR <= HARD_BP_TWO.hi) : // [R6]
			(EXEC_ADDR == HARD_BP_TWO.lo));
	end

	// trigger: edge into the active level, taken from synchronised stages only
	assign ev_trig = TRIG_EN && (TRIG_ACTIVE_HIGH ? // [R23] [R6]
		(s.trig_sync[1] & ~s.trig_sync[2]) : (~s.trig_sync[1] & s.trig_sync[2]));

	// AND / OR combination over the enabled components
	assign comp_en  = {TRIG_EN, HARD_BP_TWO.enable, HARD_BP_ONE.enable};
	assign comp_ev  = {ev_trig, ev_two, ev_one}; // [R7]
	assign comb_and = (comp_en != 3'b000) && ((comp_ev & comp_en) == comp_en); // [R8]
	assign comb_or  = (comp_ev & comp_en) != 3'b000; // [R9]
	assign ev_by_step = {1'b0, ev_trig, ev_two, ev_one};

	// sequential combination walks first, second and third step
	always_comb begin
		unique case (s.stage)
			2'd0: begin
				cur_step   = SEQ_FIRST;
				after_step = SEQ_SECOND;
			end
			2'd1: begin
				cur_step   = SEQ_SECOND;
				after_step = SEQ_THIRD;
			end
			default: begin
				cur_step   = SEQ_THIRD;
				after_step = ebu_pkg::STEP_NONE;
			end
		endcase
		seq_fire   = 1'b0;
		next_stage = s.stage;
		if (COMB_MODE == ebu_pkg::COMB_SEQ && cur_step != ebu_pkg::STEP_NONE
				&& ev_by_step[cur_step]) begin // [R10]
			if (after_step == ebu_pkg::STEP_NONE) begin
				seq_fire   = 1'b1;
				next_stage = 2'd0;
			end else begin
				next_stage = s.stage + 2'd1;
			end
		end
	end

	// breakpoint event in the active mode
	always_comb begin
		if (!s.hard_mode) begin
			bp_hit = soft_hit; // [R2]
		end else begin
			unique case (COMB_MODE)
				ebu_pkg::COMB_AND: bp_hit = comb_and; // [R8]
				ebu_pkg::COMB_OR:  bp_hit = comb_or; // [R9]
				ebu_pkg::COMB_SEQ: bp_hit = seq_fire; // [R10]
				default:           bp_hit = 1'b0;
			endcase
		end
	end

	// timer tick source and expiry
	assign div_wrap = s.div == ebu_pkg::DIV_W'(ebu_pkg::TICK_CYCLES - 1);
	assign tick     = TARGET_RUN && (TIMER_CYCLE_SRC ? MACHINE_CYCLE : div_wrap); // [R21] [R20]
	assign expired  = s.tcount >= s.limit;

	// timer break decision per mode
	always_comb begin
		timer_halt = 1'b0;
		bp_direct  = bp_hit;
		unique case (TIMER_MODE)
			ebu_pkg::timer_off_mode: begin
				timer_halt = 1'b0; // [R16]
			end
			ebu_pkg::timeout_mode: begin
				bp_direct  = 1'b0;
				timer_halt = bp_hit && s.armed && !expired; // [R17]
			end
			ebu_pkg::run_elapsed_mode: begin
				timer_halt = s.armed && expired; // [R18]
			end
			ebu_pkg::post_hit_delay_mode: begin
				bp_direct  = 1'b0;
				timer_halt = s.armed && expired; // [R19]
			end
		endcase
	end

	// break sources gathered into cause bits
	always_comb begin
		cause_set                       = '0;
		cause_set[ebu_pkg::CAUSE_BP]    = SRC_EN.bp & bp_direct; // [R12]
		cause_set[ebu_pkg::CAUSE_STACK] = SRC_EN.stack & (STACK_OVERFLOW | STACK_UNDERFLOW); // [R13]
		cause_set[ebu_pkg::CAUSE_TEVT]  = SRC_EN.trace_evt & TRACE_EVENT; // [R14]
		cause_set[ebu_pkg::CAUSE_TFULL] = SRC_EN.trace_full & TRACE_FULL; // [R15]
		cause_set[ebu_pkg::CAUSE_TIMER] = timer_halt;
		src_halt                        = cause_set != '0; // [R11]
	end

	// next state
	always_comb begin
		next_s           = s;
		next_s.hard_mode = HARD_BREAK_SEL; // [R1]
		next_s.trig_sync = {s.trig_sync[1:0], TRIG_IN}; // [R23]
		next_s.stage     = RUN_START ? 2'd0 : next_stage;
		next_s.div       = (div_wrap || !TARGET_RUN) ? '0 : s.div + 1'b1;

		// host count write, out-of-range values refused
		if (TIMER_COUNT_WR) begin
			if (TIMER_COUNT >= ebu_pkg::COUNT_MIN && TIMER_COUNT <= ebu_pkg::COUNT_MAX) begin
				next_s.limit  = TIMER_COUNT; // [R22]
				next_s.reject = 1'b0;
			end else begin
				next_s.reject = 1'b1; // [R22]
			end
		end

		// timer counter: saturating, restarted by the arming event
		if (tick && !expired) begin
			next_s.tcount = s.tcount + 1'b1;
		end
		unique case (TIMER_MODE)
			ebu_pkg::timer_off_mode: begin
				next_s.armed = 1'b0;
			end
			ebu_pkg::run_elapsed_mode: begin
				if (RUN_START) begin
					next_s.armed  = 1'b1; // [R18]
					next_s.tcount = '0;
				end else if (timer_halt) begin
					next_s.armed = 1'b0;
				end
			end
			ebu_pkg::timeout_mode: begin
				if (RUN_START) begin
					next_s.armed = 1'b0;
				end else if (bp_hit) begin
					next_s.armed  = 1'b1; // [R17]
					next_s.tcount = '0;
				end
			end
			ebu_pkg::post_hit_delay_mode: begin
				if (RUN_START || timer_halt) begin
					next_s.armed = 1'b0;
				end else if (bp_hit && !s.armed) begin
					next_s.armed  = 1'b1; // [R19]
					next_s.tcount = '0;
				end
			end
		endcase

		// halt outputs: soft break stops before, all others after unless a soft break comes in the same cycle
		next_s.halt_before = src_halt && !s.hard_mode && cause_set[ebu_pkg::CAUSE_BP]; // [R2]
		next_s.halt_after  = src_halt && !next_s.halt_before; // [R4]
		// sticky request and cause, a new break wins over the restart
		next_s.cause    = (RUN_START ? '0 : s.cause) | cause_set; // [R11]
		next_s.halt_req = (RUN_START ? 1'b0 : s.halt_req) | src_halt;
	end

	// state register
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s       <= '0;
			s.limit <= ebu_pkg::COUNT_RESET;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state register
	assign HARD_MODE_ACTIVE = s.hard_mode; // [R1]
	assign HALT_BEFORE      = s.halt_before;
	assign HALT_AFTER       = s.halt_after;
	assign HALT_REQ         = s.halt_req;
	assign BREAK_CAUSE      = s.cause;
	assign COUNT_REJECT     = s.reject;
	assign TIMER_LIMIT      = s.limit;

endmodule
`default_nettype wire

// *** inc/ebu_pkg.sv ***
// package: constants, encodings and carrier types of the emulator break event unit
package ebu_pkg;
	localparam int          ADDR_W        = 16;
	localparam int          SOFT_BP_NUM   = 8;
	localparam int          HARD_BP_NUM   = 2;
	localparam int          TIMER_W       = 16;
	// timer count limits accepted from the host
	localparam logic [15:0] COUNT_MIN     = 16'h0002;
	localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
	localparam logic [15:0] COUNT_RESET   = 16'h0002;
	// fixed time base: tick period and clock period, both in ns
	localparam int          TICK_NS       = 10_000;
	localparam int          CLK_PERIOD_NS = 4;
	localparam int          TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
	localparam int          DIV_W         = 12;
	// cause vector bit positions
	localparam int          CAUSE_BP      = 0;
	localparam int          CAUSE_STACK   = 1;
	localparam int          CAUSE_TEVT    = 2;
	localparam int          CAUSE_TFULL   = 3;
	localparam int          CAUSE_TIMER   = 4;
	localparam int          CAUSE_W       = 5;

	typedef enum logic [1:0] {
		COMB_AND = 2'b00,
		COMB_OR  = 2'b01,
		COMB_SEQ = 2'b10
	} ebu_comb_t;

	typedef enum logic [1:0] {
		timer_off_mode      = 2'b00,
		timeout_mode        = 2'b01,
		run_elapsed_mode    = 2'b10,
		post_hit_delay_mode = 2'b11
	} ebu_tmode_t;

	typedef enum logic [1:0] {
		STEP_EV_ONE = 2'b00,
		STEP_EV_TWO = 2'b01,
		STEP_TRIG = 2'b10,
		STEP_NONE = 2'b11
	} ebu_step_t;

	// one hardware address comparator: single address or range
	typedef struct packed {
		logic              enable;
		logic              range;
		logic [ADDR_W-1:0] lo;
		logic [ADDR_W-1:0] hi;
	} ebu_hw_bp_t;

	// enables of the break sources
	typedef struct packed {
		logic bp;
		logic stack;
		logic trace_evt;
		logic trace_full;
	} ebu_src_en_t;
endpackage

// *** test/ebu_break_unit_assertions.sv ***
// checker: port timing relations of the break event unit
`timescale 1ns/1ps
`default_nettype none
module ebu_break_unit_assertions (
	input wire logic                 REF_CLK,
	input wire logic                 RST_N,
	input wire logic                 HARD_BREAK_SEL,
	input wire logic                 RUN_START,
	input wire ebu_pkg::ebu_src_en_t SRC_EN,
	input wire logic                 STACK_OVERFLOW,
	input wire logic                 STACK_UNDERFLOW,
	input wire logic [15:0]          TIMER_COUNT,
	input wire logic                 TIMER_COUNT_WR,
	input wire logic                 HARD_MODE_ACTIVE,
	input wire logic                 HALT_BEFORE,
	input wire logic                 HALT_AFTER,
	input wire logic                 HALT_REQ,
	input wire logic [4:0]           BREAK_CAUSE,
	input wire logic                 COUNT_REJECT,
	input wire logic [15:0]          TIMER_LIMIT
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	// count writes split by the accepted range
	sequence s_bad_wr;
		TIMER_COUNT_WR && TIMER_COUNT < ebu_pkg::COUNT_MIN;
	endsequence
	sequence s_good_wr;
		TIMER_COUNT_WR && TIMER_COUNT >= ebu_pkg::COUNT_MIN;
	endsequence
	// halt outputs, mode report and count handling
	AST_MODE_REPORT: assert property ($changed(HARD_BREAK_SEL) |=>
		HARD_MODE_ACTIVE == $past(HARD_BREAK_SEL)) else $error("mode report wrong");
	AST_SOFT_HALT: assert property (HALT_BEFORE |-> HALT_REQ && BREAK_CAUSE[0])
		else $error("soft halt without cause");
	AST_ONE_KIND: assert property (HALT_BEFORE |->
		!HALT_AFTER && !$past(HARD_MODE_ACTIVE)) else $error("soft halt outside soft mode");
	AST_STACK: assert property (SRC_EN.stack && (STACK_OVERFLOW || STACK_UNDERFLOW)
		|=> HALT_REQ && BREAK_CAUSE[1]) else $error("stack event not halting");
	AST_BAD_COUNT: assert property (s_bad_wr |=> COUNT_REJECT && $stable(TIMER_LIMIT))
		else $error("bad count taken");
	AST_GOOD_COUNT: assert property (s_good_wr |=>
		!COUNT_REJECT && TIMER_LIMIT == $past(TIMER_COUNT)) else $error("good count lost");
	AST_HALT_HOLD: assert property (HALT_REQ && !RUN_START |=> HALT_REQ)
		else $error("halt request dropped");
	AST_HALT_PULSE: assert property ($rose(HALT_REQ) |-> HALT_BEFORE || HALT_AFTER)
		else $error("halt request without pulse");
endmodule
bind ebu_break_unit ebu_break_unit_assertions i_chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
	.HARD_BREAK_SEL(HARD_BREAK_SEL), .RUN_START(RUN_START), .SRC_EN(SRC_EN),
	.STACK_OVERFLOW(STACK_OVERFLOW), .STACK_UNDERFLOW(STACK_UNDERFLOW),
	.TIMER_COUNT(TIMER_COUNT), .TIMER_COUNT_WR(TIMER_COUNT_WR),
	.HARD_MODE_ACTIVE(HARD_MODE_ACTIVE), .HALT_BEFORE(HALT_BEFORE), .HALT_AFTER(HALT_AFTER),
	.HALT_REQ(HALT_REQ), .BREAK_CAUSE(BREAK_CAUSE), .COUNT_REJECT(COUNT_REJECT),
	.TIMER_LIMIT(TIMER_LIMIT));
`default_nettype wire

// *** test/ebu_core_model.sv ***
// target core model: fetch, completion and machine cycle strobes
`timescale 1ns/1ps
`default_nettype none
module ebu_core_model #(
	parameter int MC_DIV = 2
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        go,
	input  wire logic [15:0] addr,
	input  wire logic        run,
	output logic             fv,
	output logic [15:0]      fa,
	output logic             ed,
	output logic [15:0]      ea,
	output logic             mc
);
	int cnt;
	// fetch on request, completion a cycle later; idle address lines toggle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{fv, ed, mc, fa, ea} <= '0;
			cnt <= 0;
		end else begin
			fv <= go;
			fa <= go ? addr : ~fa;
			ed <= fv;
			ea <= fv ? fa : ~ea;
			cnt <= (cnt + 1) % MC_DIV;
			mc <= run && cnt == 0;
		end
	end
endmodule
`default_nettype wire

// *** test/ebu_break_unit_test.sv ***
// testbench: breakpoint table, then sequence, trigger, sources and timer cases
`timescale 1ns/1ps
`default_nettype none
module ebu_break_unit_test;
	typedef struct packed {
		logic        h;
		logic [1:0]  c;
		logic [15:0] a;
		logic        b;
		logic        f;
	} ebu_row_t;
	ebu_row_t             rows [8] = '{'{1'b0, 2'h1, 16'h0103, 1'b1, 1'b0},
		'{1'b0, 2'h1, 16'h0107, 1'b0, 1'b0}, '{1'b0, 2'h1, 16'h0305, 1'b0, 1'b0},
		'{1'b1, 2'h1, 16'h0300, 1'b0, 1'b1}, '{1'b1, 2'h1, 16'h0310, 1'b0, 1'b0},
		'{1'b1, 2'h0, 16'h0305, 1'b0, 1'b1}, '{1'b1, 2'h0, 16'h030F, 1'b0, 1'b0},
		'{1'b1, 2'h1, 16'h0103, 1'b0, 1'b0}};
	logic                 clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, trig_en = 1'b0, trig = 1'b0;
	logic                 twr = 1'b0, rs = 1'b0, go = 1'b0, run = 1'b0, tcs = 1'b0, q;
	logic                 so = 1'b0, su = 1'b0, te = 1'b0, tf = 1'b0, sb, sa;
	logic                 hma, hb, ha, hr, rej, fv, ed, mc;
	logic [15:0]          addr = 16'h0000, tcnt = 16'h0002, lim, fa, ea;
	logic [7:0][15:0]     sba;
	logic [4:0]           cause;
	logic [7:0]           sben = 8'h7F;
	logic                 tah = 1'b1;
	ebu_pkg::ebu_hw_bp_t  h1, h2;
	ebu_pkg::ebu_comb_t   comb = ebu_pkg::COMB_OR;
	ebu_pkg::ebu_step_t   s1 = ebu_pkg::STEP_EV_TWO, s2 = ebu_pkg::STEP_EV_ONE;
	ebu_pkg::ebu_step_t   s3 = ebu_pkg::STEP_NONE;
	ebu_pkg::ebu_src_en_t src = 4'h8;
	ebu_pkg::ebu_tmode_t  tmode = ebu_pkg::timer_off_mode;
	int                   fail_count = 0, checks_done = 0, np = 0;

	ebu_break_unit i_dut (.REF_CLK(clk), .RST_N(rst_n), .HARD_BREAK_SEL(hsel),
		.SOFT_BP_ADDR(sba), .SOFT_BP_EN(sben), .HARD_BP_ONE(h1), .HARD_BP_TWO(h2),
		.TRIG_EN(trig_en), .TRIG_ACTIVE_HIGH(tah), .TRIG_IN(trig), .COMB_MODE(comb),
		.SEQ_FIRST(s1), .SEQ_SECOND(s2), .SEQ_THIRD(s3), .SRC_EN(src),
		.TIMER_MODE(tmode), .TIMER_CYCLE_SRC(tcs), .TIMER_COUNT(tcnt), .TIMER_COUNT_WR(twr),
		.RUN_START(rs), .TARGET_RUN(run), .FETCH_VALID(fv), .FETCH_ADDR(fa), .EXEC_DONE(ed),
		.EXEC_ADDR(ea), .MACHINE_CYCLE(mc), .STACK_OVERFLOW(so), .STACK_UNDERFLOW(su),
		.TRACE_EVENT(te), .TRACE_FULL(tf), .HARD_MODE_ACTIVE(hma), .HALT_BEFORE(hb),
		.HALT_AFTER(ha), .HALT_REQ(hr), .BREAK_CAUSE(cause), .COUNT_REJECT(rej),
		.TIMER_LIMIT(lim));
	ebu_core_model i_core (.clk(clk), .rst_n(rst_n), .go(go), .addr(addr), .run(run),
		.fv(fv), .fa(fa), .ed(ed), .ea(ea), .mc(mc));

	// 250 MHz clock
	always #2 clk = ~clk;

	// compare, report and finish
	task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d errors=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// run start clears halt state and the seen flags
	task automatic clr();
		@(posedge clk);
		rs <= 1'b1;
		@(posedge clk);
		rs <= 1'b0;
		{sb, sa, np} = '0;
		#1;
	endtask
	// one instruction through the core model
	task automatic hit(input logic [15:0] a);
		@(posedge clk);
		go <= 1'b1;
		addr <= a;
		@(posedge clk);
		go <= 1'b0;
	endtask
	// watch halt pulses for n cycles
	task automatic obs(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			sb |= hb;
			sa |= ha;
			np += int'(ha);
		end
	endtask
	task automatic wr(input logic [15:0] v);
		@(posedge clk);
		tcnt <= v;
		twr <= 1'b1;
		@(posedge clk);
		twr <= 1'b0;
		#1;
	endtask
	task automatic wait_hr(input int n);
		for (int i = 0; i < n && hr !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (hr !== 1'b1) begin
			fail_count++;
			conclude();
		end
	endtask
	// timer case: q holds the halt request before the interval is due
	task automatic tmr(input ebu_pkg::ebu_tmode_t m, input logic c, input logic [15:0] v,
		input int h, input int qn, input int wn);
		tmode <= m;
		tcs <= c;
		wr(v);
		clr();
		for (int i = 0; i < h; i++) begin
			q = hr;
			hit(16'h0103);
			obs(4);
		end
		repeat (qn) @(posedge clk);
		#1;
		if (h < 2) q = hr;
		wait_hr(wn);
	endtask

	// main sequence
	initial begin
		h1 = '{1'b1, 1'b0, 16'h0305, 16'h0000};
		h2 = '{1'b1, 1'b1, 16'h0300, 16'h030F};
		for (int i = 0; i < 8; i++) sba[i] = 16'h0100 + 16'(i);
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk(20'({hma, hb, ha, hr, rej, cause}), 20'h0_0000);
		chk(20'(lim), 20'h0_0002);
		foreach (rows[i]) begin
			hsel <= rows[i].h;
			comb <= ebu_pkg::ebu_comb_t'(rows[i].c);
			clr();
			hit(rows[i].a);
			obs(5);
			chk(20'({hma, sb, sa}), 20'({rows[i].h, rows[i].b, rows[i].f}));
			chk(20'(cause), 20'(rows[i].b | rows[i].f));
		end
		hsel <= 1'b1;
		comb <= ebu_pkg::COMB_SEQ;
		clr();
		for (int j = 0; j < 3; j++) begin
			hit(j == 2 ? 16'h0305 : 16'h0300);
			obs(5);
			chk(20'(sa), 20'(j == 2));
		end
		comb <= ebu_pkg::COMB_OR;
		h1.enable <= 1'b0;
		h2.enable <= 1'b0;
		trig_en <= 1'b1;
		clr();
		trig <= 1'b1;
		obs(10);
		chk(20'(np), 20'h0_0001);
		// three-step sequence: second address event, first, then trigger
		s3 <= ebu_pkg::STEP_TRIG;
		comb <= ebu_pkg::COMB_SEQ;
		h1.enable <= 1'b1;
		h2.enable <= 1'b1;
		trig <= 1'b0;
		clr();
		hit(16'h0300);
		hit(16'h0305);
		obs(4);
		chk(20'(sa), 20'h0_0000);
		trig <= 1'b1;
		obs(5);
		chk(20'(sa), 20'h0_0001);
		// falling edge with the trigger set active low
		tah <= 1'b0;
		comb <= ebu_pkg::COMB_OR;
		h1.enable <= 1'b0;
		h2.enable <= 1'b0;
		clr();
		trig <= 1'b0;
		obs(10);
		chk(20'(np), 20'h0_0001);
		trig_en <= 1'b0;
		for (int k = 0; k < 5; k++) begin
			src <= ebu_pkg::ebu_src_en_t'(k < 2 || k == 4 ? 4'h4 : 4'h8 >> k);
			clr();
			{so, su, te, tf} <= k == 4 ? 4'hF : 4'h8 >> k;
			@(posedge clk);
			{so, su, te, tf} <= 4'h0;
			obs(3);
			chk(20'(cause), 20'(k < 2 || k == 4 ? 5'h02 : 5'h01 << k));
		end
		src <= 4'h8;
		hsel <= 1'b0;
		// enabling the last soft address makes it break
		sben <= 8'hFF;
		clr();
		hit(16'h0107);
		obs(4);
		chk(20'(sb), 20'h0_0001);
		run <= 1'b1;
		wr(16'h0001);
		chk(20'({rej, lim}), 20'h1_0002);
		wr(16'h0000);
		chk(20'({rej, lim}), 20'h1_0002);
		wr(16'hFFFF);
		chk(20'({rej, lim}), 20'h0_FFFF);
		tmr(ebu_pkg::run_elapsed_mode, 1'b0, 16'h0002, 0, 4000, 1500);
		chk(20'({q, cause}), 20'h0_0010);
		tmr(ebu_pkg::run_elapsed_mode, 1'b1, 16'h0006, 0, 6, 20);
		chk(20'({q, cause}), 20'h0_0010);
		tmr(ebu_pkg::post_hit_delay_mode, 1'b1, 16'h0006, 1, 0, 30);
		chk(20'({q, cause}), 20'h0_0010);
		tmr(ebu_pkg::timeout_mode, 1'b1, 16'h0008, 2, 0, 8);
		chk(20'({q, cause}), 20'h0_0010);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk(20'({hr, cause}), 20'h0_0000);
		chk(20'(lim), 20'h0_0002);
		conclude();
	end
endmodule
`default_nettype wire
